//--- bsgo_top.sv
// Statistics counters and general options of a SCSI host adapter.
// Assumes a plain register port and a host memory write port with grant
// and acknowledge handshakes; event inputs are one-cycle pulses.
`timescale 1ns/10ps
module bsgo_top
   import bsgo_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic evtCmdProcessed,
   input wire logic evtCmdIssued,
   input wire logic [3:0] evtIssuedId,
   input wire logic evtCheckCond,
   input wire logic evtTargetSel,
   input wire logic [3:0] jumperId,
   output logic [3:0] scsiId,
   output logic [3:0] burstExp,
   output logic busReq,
   input wire logic busGrant,
   output logic memWr,
   input wire logic memAck,
   output logic [31:0] memAddr,
   output logic [31:0] memData,
   output logic [7:0] memAm,
   output logic cmdDone,
   output logic [31:0] cmdDoneId,
   output logic cmdDoneErr
);
   import bsgo_pkg::*;

   typedef struct packed {
      bsgo_state_t st;
      logic [STAT_WORDS-1:0] pend;
      logic [4:0] word;
      logic [4:0] incIdx;
      logic [3:0] thr;
      logic [3:0] scsiId;
      logic idLoaded;
      logic [31:0] pbId;
      logic [31:0] pbW1;
      logic [31:0] pbAddr;
      logic [31:0] pbCmd;
      logic cmdPend;
      logic clrCmd;
      logic [11:0] sent;
      logic busReq;
      logic memWr;
      logic [31:0] memAddr;
      logic [31:0] memData;
      logic [7:0] memAm;
      logic done;
      logic [31:0] doneId;
      logic doneErr;
      logic [31:0] rdata;
   } bsgo_regs_t;

   bsgo_regs_t s_ff;
   bsgo_regs_t nxt_s;
   bsgo_mem_if mif ();
   logic [STAT_WORDS-1:0] evtSet;
   logic [4:0] pick;
   logic pickValid;
   logic [11:0] burstBytes;

   bsgo_ctr_mem u_mem (
      .clk(clk),
      .mif(mif)
   );

   // Lowest-index pending counter wins the memory.
   function automatic logic [4:0] lowest(input logic [STAT_WORDS-1:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = STAT_WORDS - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = 5'(i);
         end
      end
      return r;
   endfunction: lowest

   always_comb
   begin
      evtSet = '0;
      evtSet[bsgo_idx(STAT_TOTAL_OFS)] = evtCmdProcessed;
      evtSet[bsgo_idx(STAT_CHECK_OFS)] = evtCheckCond;
      evtSet[bsgo_idx(STAT_TARGET_OFS)] = evtTargetSel;
      if (evtCmdIssued)
      begin
         evtSet[bsgo_id_idx(evtIssuedId)] = 1'b1;
      end
   end

   assign pick = lowest(s_ff.pend);
   assign pickValid = |s_ff.pend;
   // Bursts under one word still move one word: transfers are word wide.
   assign burstBytes = 12'(1) << s_ff.thr;

   always_comb
   begin
      logic [STAT_WORDS-1:0] served;
      logic [7:0] code;
      served = '0;
      code = s_ff.pbCmd[31:24];
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      nxt_s.rdata = CNT_ZERO;
      mif.addr = s_ff.word;
      mif.we = 1'b0;
      mif.wdata = CNT_ZERO;
      if (!s_ff.idLoaded)
      begin
         nxt_s.scsiId = jumperId;
         nxt_s.idLoaded = 1'b1;
      end
      if (regRd)
      begin
         case (regAddr)
            PB_ID_OFS: nxt_s.rdata = s_ff.pbId;
            PB_W1_OFS: nxt_s.rdata = s_ff.pbW1;
            PB_ADDR_OFS: nxt_s.rdata = s_ff.pbAddr;
            PB_CMD_OFS: nxt_s.rdata = s_ff.pbCmd;
            STATUS_OFS: nxt_s.rdata = {29'h0, s_ff.doneErr,
                                       s_ff.st != S_IDLE, s_ff.cmdPend};
            SETTINGS_OFS: nxt_s.rdata = {24'h0, s_ff.thr, s_ff.scsiId};
            DONE_ID_OFS: nxt_s.rdata = s_ff.doneId;
            default: nxt_s.rdata = CNT_ZERO;
         endcase
      end
      // The parameter block is locked while a command is outstanding.
      if (regWr && !s_ff.cmdPend)
      begin
         case (regAddr)
            PB_ID_OFS: nxt_s.pbId = regWdata;
            PB_W1_OFS: nxt_s.pbW1 = regWdata;
            PB_ADDR_OFS: nxt_s.pbAddr = regWdata;
            PB_CMD_OFS:
            begin
               nxt_s.pbCmd = regWdata;
               nxt_s.cmdPend = 1'b1;
            end
            default: nxt_s.pbW1 = s_ff.pbW1;
         endcase
      end
      case (s_ff.st)
         S_CLR:
         begin
            mif.we = 1'b1;
            mif.wdata = CNT_ZERO;
            nxt_s.word = s_ff.word + 5'd1;
            if (s_ff.word == STAT_LAST)
            begin
               nxt_s.word = 5'h00;
               nxt_s.st = s_ff.clrCmd ? S_DONE : S_IDLE;
            end
         end
         S_IDLE:
         begin
            if (s_ff.cmdPend)
            begin
               nxt_s.doneErr = 1'b0;
               nxt_s.st = S_DONE;
               if (s_ff.pbW1[7:0] != BOARD_ADAPTER_ID)
               begin
                  nxt_s.doneErr = 1'b1;
               end
               else if (code == CMD_GENOPT)
               begin
                  // byte 1 is the throttle, byte 2 the bus ID.
                  if (s_ff.pbW1[23:16] > THR_MAX ||
                      s_ff.pbW1[15:8] > BUS_ID_MAX)
                  begin
                     nxt_s.doneErr = 1'b1;
                  end
                  else
                  begin
                     nxt_s.thr = s_ff.pbW1[19:16];
                     nxt_s.scsiId = s_ff.pbW1[11:8];
                  end
               end
               else if (code == CMD_STATS && s_ff.pbCmd[16+CLR_BIT])
               begin
                  nxt_s.clrCmd = 1'b1;
                  nxt_s.word = 5'h00;
                  served = '1;
                  nxt_s.st = S_CLR;
               end
               else if (code == CMD_STATS)
               begin
                  nxt_s.memAm = s_ff.pbW1[15:8];
                  nxt_s.word = 5'h00;
                  nxt_s.st = S_GRANT;
               end
               else
               begin
                  nxt_s.doneErr = 1'b1;
               end
            end
            else if (pickValid)
            begin
               mif.addr = pick;
               nxt_s.incIdx = pick;
               served[pick] = 1'b1;
               nxt_s.st = S_INC_RD;
            end
         end
         S_INC_RD:
         begin
            mif.addr = s_ff.incIdx;
            nxt_s.st = S_INC_WR;
         end
         S_INC_WR:
         begin
            mif.addr = s_ff.incIdx;
            mif.we = 1'b1;
            mif.wdata = mif.rdata + CNT_ONE;
            nxt_s.st = S_IDLE;
         end
         S_GRANT:
         begin
            nxt_s.busReq = 1'b1;
            nxt_s.sent = 12'h000;
            if (s_ff.busReq && busGrant)
            begin
               nxt_s.st = S_FETCH;
            end
         end
         S_FETCH:
         begin
            nxt_s.memAddr = s_ff.pbAddr + {25'h0, s_ff.word, 2'b00};
            nxt_s.memData = mif.rdata;
            nxt_s.memWr = 1'b1;
            nxt_s.st = S_WRITE;
         end
         S_WRITE:
         begin
            if (memAck)
            begin
               nxt_s.memWr = 1'b0;
               nxt_s.word = s_ff.word + 5'd1;
               nxt_s.sent = s_ff.sent + WORD_BYTES;
               mif.addr = s_ff.word + 5'd1;
               if (s_ff.word == STAT_LAST)
               begin
                  nxt_s.busReq = 1'b0;
                  nxt_s.doneErr = 1'b0;
                  nxt_s.st = S_DONE;
               end
               else if (s_ff.sent + WORD_BYTES >= burstBytes)
               begin
                  nxt_s.busReq = 1'b0;
                  nxt_s.st = S_GRANT;
               end
               else
               begin
                  nxt_s.st = S_FETCH;
               end
            end
         end
         S_DONE:
         begin
            // the identifier goes back with the completion.
            nxt_s.done = 1'b1;
            nxt_s.doneId = s_ff.pbId;
            nxt_s.cmdPend = 1'b0;
            nxt_s.clrCmd = 1'b0;
            nxt_s.st = S_IDLE;
         end
         default: nxt_s.st = S_IDLE;
      endcase
      nxt_s.pend = (s_ff.pend & ~served) | evtSet;
      if (s_ff.st == S_DONE)
      begin
         nxt_s.pend[bsgo_idx(STAT_TOTAL_OFS)] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_ff <= '0;
         s_ff.st <= S_CLR;
         s_ff.thr <= THR_DEFAULT;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign regRdata = s_ff.rdata;
   assign scsiId = s_ff.scsiId;
   assign burstExp = s_ff.thr;
   assign busReq = s_ff.busReq;
   assign memWr = s_ff.memWr;
   assign memAddr = s_ff.memAddr;
   assign memData = s_ff.memData;
   assign memAm = s_ff.memAm;
   assign cmdDone = s_ff.done;
   assign cmdDoneId = s_ff.doneId;
   assign cmdDoneErr = s_ff.doneErr;

   thr_range_a: assert property (
      @(posedge clk) disable iff (!rst_n) s_ff.thr <= THR_DEFAULT)
      else $error("Throttle exponent out of range.");

   default_thr_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> s_ff.thr == THR_DEFAULT)
      else $error("Throttle not at default after reset.");

   reject_keep_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s_ff.st == S_IDLE && s_ff.cmdPend &&
       s_ff.pbCmd[31:24] == CMD_GENOPT &&
       s_ff.pbW1[23:16] > THR_MAX) |=> $stable(s_ff.thr) ##1 cmdDoneErr)
      else $error("Bad throttle was not rejected.");

   id_replace_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (s_ff.st == S_IDLE && s_ff.cmdPend &&
       s_ff.pbCmd[31:24] == CMD_GENOPT &&
       s_ff.pbW1[7:0] == BOARD_ADAPTER_ID &&
       s_ff.pbW1[23:16] <= THR_MAX && s_ff.pbW1[15:8] <= BUS_ID_MAX)
      |=> scsiId == $past(s_ff.pbW1[11:8]) ##1 cmdDone && !cmdDoneErr)
      else $error("Bus ID not taken from options.");

   burst_limit_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      memWr |-> s_ff.sent < burstBytes || s_ff.sent == 12'h000)
      else $error("Burst length exceeded.");

   addr_map_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(memWr) |-> memAddr == s_ff.pbAddr + {25'h0, s_ff.word, 2'b00}
      && memAm == s_ff.pbW1[15:8])
      else $error("Statistics word at wrong address.");

   clr_zero_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      s_ff.st == S_CLR |-> mif.we && mif.wdata == CNT_ZERO && !memWr)
      else $error("Clear did not zero the counter.");

   check_pend_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      evtCheckCond |=> s_ff.pend[bsgo_idx(STAT_CHECK_OFS)])
      else $error("Check condition not recorded.");

   inc_one_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      s_ff.st == S_INC_RD |=> mif.we && mif.wdata == mif.rdata + CNT_ONE)
      else $error("Counter did not advance by one.");
endmodule: bsgo_top

//--- bsgo_pkg.sv
// Constants and types for the board statistics and general options block.
// Assumes a 10 MHz clock and a big-endian host word: byte 0 is bits 31:24.
package bsgo_pkg;
   localparam logic [7:0] PB_ID_OFS = 8'h00;
   localparam logic [7:0] PB_W1_OFS = 8'h04;
   localparam logic [7:0] PB_ADDR_OFS = 8'h08;
   localparam logic [7:0] PB_CMD_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h20;
   localparam logic [7:0] SETTINGS_OFS = 8'h24;
   localparam logic [7:0] DONE_ID_OFS = 8'h28;
   localparam logic [7:0] CMD_STATS = 8'h06;
   localparam logic [7:0] CMD_GENOPT = 8'h07;
   localparam logic [7:0] BOARD_ADAPTER_ID = 8'hFF;
   localparam logic [7:0] THR_MAX = 8'h0B;
   localparam logic [7:0] BUS_ID_MAX = 8'h0F;
   localparam logic [3:0] THR_DEFAULT = 4'hB;
   localparam int CLR_BIT = 0;
   localparam logic [7:0] STAT_TOTAL_OFS = 8'h00;
   localparam logic [7:0] STAT_ID0_OFS = 8'h04;
   localparam logic [7:0] STAT_CHECK_OFS = 8'h24;
   localparam logic [7:0] STAT_ID8_OFS = 8'h28;
   localparam logic [7:0] STAT_TARGET_OFS = 8'h48;
   localparam int STAT_WORDS = 19;
   localparam logic [4:0] STAT_LAST = 5'h12;
   localparam logic [11:0] WORD_BYTES = 12'h004;
   localparam int MEM_DEPTH = 32;
   localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
   localparam logic [31:0] CNT_ONE = 32'h0000_0001;

   typedef enum logic [2:0] {
      S_CLR, S_IDLE, S_INC_RD, S_INC_WR, S_GRANT, S_FETCH, S_WRITE, S_DONE
   } bsgo_state_t;

   // Word index of a statistics byte offset.
   function automatic logic [4:0] bsgo_idx(input logic [7:0] ofs);
      return ofs[6:2];
   endfunction: bsgo_idx

   // Word index of the issued-command counter for a SCSI ID.
   function automatic logic [4:0] bsgo_id_idx(input logic [3:0] id);
      logic [4:0] base;
      base = id[3] ? bsgo_idx(STAT_ID8_OFS) : bsgo_idx(STAT_ID0_OFS);
      return base + {2'b00, id[2:0]};
   endfunction: bsgo_id_idx
endpackage: bsgo_pkg

//--- bsgo_mem_if.sv
// Port bundle between the sequencer and the counter memory.
// Assumes one clock domain; the read data are registered in the memory.
`timescale 1ns/10ps
interface bsgo_mem_if;
   logic [4:0] addr;
   logic we;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport ctl (output addr, output we, output wdata, input rdata);
   modport mem (input addr, input we, input wdata, output rdata);
endinterface: bsgo_mem_if

//--- bsgo_ctr_mem.sv
// Single-port counter memory with registered read data.
// Assumes the sequencer zeroes it after reset; cells have no reset.
`timescale 1ns/10ps
module bsgo_ctr_mem
   import bsgo_pkg::*;
(
   input wire logic clk,
   bsgo_mem_if.mem mif
);
   logic [31:0] cells [MEM_DEPTH];
   logic [31:0] rdata_ff;

   always_ff @(posedge clk)
   begin
      if (mif.we)
      begin
         cells[mif.addr] <= mif.wdata;
      end
      rdata_ff <= cells[mif.addr];
   end

   assign mif.rdata = rdata_ff;
endmodule: bsgo_ctr_mem

//--- bsgo_host_model.sv
// Host side model: bus arbiter plus host memory taking statistics words.
// Assumes one clock; grant follows the request one cycle later.
`timescale 1ns/10ps
module bsgo_host_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] ackLat,
   input wire logic [31:0] memBase,
   input wire logic busReq,
   output logic busGrant,
   input wire logic memWr,
   output logic memAck,
   input wire logic [31:0] memAddr,
   input wire logic [31:0] memData,
   input wire logic [7:0] memAm,
   output logic [7:0] lastAm,
   output logic [7:0] maxWords,
   output logic [7:0] badAddr
);
   logic [31:0] hostMem [0:18];
   logic [3:0] waitCnt;
   logic [7:0] curWords;
   logic [31:0] ofs;
   assign ofs = memAddr - memBase;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busGrant <= 1'b0;
         memAck <= 1'b0;
         waitCnt <= 4'h0;
         curWords <= 8'h00;
         maxWords <= 8'h00;
         badAddr <= 8'h00;
         lastAm <= 8'h00;
      end
      else
      begin
         busGrant <= busReq;
         // The acknowledge is a single pulse after ackLat waiting cycles.
         if (memWr && !memAck)
         begin
            if (waitCnt >= ackLat)
            begin
               memAck <= 1'b1;
               waitCnt <= 4'h0;
            end
            else
               waitCnt <= waitCnt + 4'h1;
         end
         else
            memAck <= 1'b0;
         if (!busGrant)
            curWords <= 8'h00;
         else if (memWr && memAck)
         begin
            curWords <= curWords + 8'h01;
            if (curWords + 8'h01 > maxWords)
               maxWords <= curWords + 8'h01;
         end
         if (memWr && memAck)
         begin
            lastAm <= memAm;
            if (ofs < 32'h0000_004C && ofs[1:0] == 2'b00)
               hostMem[ofs[6:2]] <= memData;
            else
               badAddr <= badAddr + 8'h01;
         end
      end
   end
endmodule: bsgo_host_model

//--- board_stats_and_general_options_tb.sv
// Self-checking bench for the statistics and general options block.
// Assumes the host model answers every memory write and grant request.
`timescale 1ns/10ps
module board_stats_and_general_options_tb;
   logic clk, rst_n, regWr, regRd, busGrant, memAck, memWr, busReq;
   logic evtCmdProcessed, evtCmdIssued, evtCheckCond, evtTargetSel;
   logic cmdDone, cmdDoneErr;
   logic [7:0] regAddr, memAm, lastAm, maxWords, badAddr;
   logic [31:0] regWdata, regRdata, memAddr, memData, cmdDoneId, rdVal;
   logic [3:0] evtIssuedId, jumperId, scsiId, burstExp, ackLat;
   logic [31:0] expStat [0:18];
   int n_fail, tests_run, cycles, wrSeen, mark;

   bsgo_top dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .evtCmdProcessed(evtCmdProcessed),
      .evtCmdIssued(evtCmdIssued), .evtIssuedId(evtIssuedId),
      .evtCheckCond(evtCheckCond), .evtTargetSel(evtTargetSel),
      .jumperId(jumperId), .scsiId(scsiId), .burstExp(burstExp),
      .busReq(busReq), .busGrant(busGrant), .memWr(memWr),
      .memAck(memAck), .memAddr(memAddr), .memData(memData),
      .memAm(memAm), .cmdDone(cmdDone), .cmdDoneId(cmdDoneId),
      .cmdDoneErr(cmdDoneErr));
   bsgo_host_model host (.clk(clk), .rst_n(rst_n), .ackLat(ackLat),
      .memBase(32'h0000_1000), .busReq(busReq), .busGrant(busGrant),
      .memWr(memWr), .memAck(memAck), .memAddr(memAddr),
      .memData(memData), .memAm(memAm), .lastAm(lastAm),
      .maxWords(maxWords), .badAddr(badAddr));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic final_report();
      if (n_fail == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask: final_report

   always @(posedge clk)
   begin
      cycles++;
      if (memWr)
         wrSeen++;
      if (cycles == 20000)
      begin
         n_fail++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string what);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask: chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask: wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      rdVal = regRdata;
   endtask: rd

   // Writes a parameter block, launches it and waits for completion.
   task automatic issue(input logic [31:0] id, input logic [31:0] w1,
         input logic [31:0] cmd);
      int i;
      wr(8'h00, id);
      wr(8'h04, w1);
      wr(8'h08, 32'h0000_1000);
      wr(8'h10, cmd);
      for (i = 0; i < 3000; i++)
      begin
         @(posedge clk);
         #1;
         if (cmdDone === 1'b1)
            break;
      end
      chk({31'h0, cmdDone}, 32'h1, "no completion");
      chk(cmdDoneId, id, "done identifier");
   endtask: issue

   task automatic evt(input int k, input logic [3:0] id);
      @(posedge clk);
      evtIssuedId <= id;
      case (k)
         0: evtCmdProcessed <= 1'b1;
         1: evtCmdIssued <= 1'b1;
         2: evtCheckCond <= 1'b1;
         default: evtTargetSel <= 1'b1;
      endcase
      @(posedge clk);
      evtCmdProcessed <= 1'b0;
      evtCmdIssued <= 1'b0;
      evtCheckCond <= 1'b0;
      evtTargetSel <= 1'b0;
      repeat (3) @(posedge clk);
   endtask: evt

   task automatic t_defaults();
      repeat (25) @(posedge clk);
      #1;
      chk({28'h0, burstExp}, 32'hB, "default throttle");
      chk({28'h0, scsiId}, 32'h6, "jumper id");
      rd(8'h24);
      chk(rdVal, 32'h0000_00B6, "settings word");
      rd(8'h3C);
      chk(rdVal, 32'h0, "unmapped read");
   endtask: t_defaults

   task automatic t_options();
      issue(32'h0000_0011, 32'h0103_05FF, 32'h0700_0000);
      chk({31'h0, cmdDoneErr}, 32'h0, "options error");
      chk({28'h0, burstExp}, 32'h3, "throttle");
      chk({28'h0, scsiId}, 32'h5, "bus id");
      rd(8'h24);
      chk(rdVal, 32'h0000_0035, "settings word");
      rd(8'h28);
      chk(rdVal, 32'h0000_0011, "done id register");
      issue(32'h0000_0012, 32'h010C_0AFF, 32'h0700_0000);
      chk({31'h0, cmdDoneErr}, 32'h1, "big throttle");
      chk({28'h0, burstExp}, 32'h3, "throttle kept");
      issue(32'h0000_0013, 32'h0104_0700, 32'h0700_0000);
      chk({31'h0, cmdDoneErr}, 32'h1, "bad adapter id");
      chk({28'h0, scsiId}, 32'h5, "id kept");
      issue(32'h0000_0017, 32'h0000_00FF, 32'h0900_0000);
      chk({31'h0, cmdDoneErr}, 32'h1, "unknown code");
   endtask: t_options

   task automatic t_stats();
      int i;
      int j;
      for (i = 0; i < 19; i++)
         expStat[i] = 32'h0;
      for (i = 0; i < 16; i++)
      begin
         for (j = 0; j <= i % 3; j++)
            evt(1, i[3:0]);
         expStat[i < 8 ? i + 1 : i + 2] = (i % 3) + 1;
      end
      for (i = 0; i < 3; i++)
         evt(3, 4'h0);
      for (i = 0; i < 2; i++)
         evt(2, 4'h0);
      for (i = 0; i < 4; i++)
         evt(0, 4'h0);
      expStat[9] = 32'h2;
      expStat[18] = 32'h3;
      ackLat <= 4'h5;
      issue(32'h0000_0014, 32'h0000_3DFF, 32'h0600_0000);
      for (i = 1; i < 18; i++)
         if (i != 9)
            chk(host.hostMem[i], expStat[i], "id count");
      chk(host.hostMem[9], expStat[9], "check count");
      chk(host.hostMem[18], expStat[18], "target count");
      // Four board commands completed earlier plus four processed events.
      chk(host.hostMem[0], 32'h0000_0008, "total count");
      chk({24'h0, lastAm}, 32'h3D, "address modifier");
      chk({24'h0, badAddr}, 32'h0, "write address");
      chk({24'h0, maxWords}, 32'h2, "burst words");
   endtask: t_stats

   task automatic t_clear();
      int i;
      ackLat <= 4'h0;
      mark = wrSeen;
      issue(32'h0000_0015, 32'h0000_3DFF, 32'h0601_0000);
      chk(wrSeen - mark, 32'h0, "clear wrote");
      issue(32'h0000_0016, 32'h0000_3DFF, 32'h0600_0000);
      for (i = 1; i < 19; i++)
         chk(host.hostMem[i], 32'h0, "cleared count");
      chk(host.hostMem[0], 32'h0000_0001, "total after clear");
   endtask: t_clear

   task automatic t_midreset();
      @(posedge clk);
      jumperId <= 4'h9;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({28'h0, burstExp}, 32'hB, "throttle in reset");
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (25) @(posedge clk);
      #1;
      chk({28'h0, scsiId}, 32'h9, "jumper after reset");
      chk({28'h0, burstExp}, 32'hB, "throttle after reset");
   endtask: t_midreset

   initial
   begin
      rst_n = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      evtCmdProcessed = 1'b0;
      evtCmdIssued = 1'b0;
      evtCheckCond = 1'b0;
      evtTargetSel = 1'b0;
      evtIssuedId = 4'h0;
      jumperId = 4'h6;
      ackLat = 4'h0;
      n_fail = 0;
      tests_run = 0;
      cycles = 0;
      wrSeen = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_defaults();
      t_options();
      t_stats();
      t_clear();
      t_midreset();
      final_report();
   end
endmodule: board_stats_and_general_options_tb
